/* sim/bhms_host.sv */
// Host model: register strobes and chip select
`timescale 1ns/10ps
`default_nettype none
module bhms_host (
  // Clock
  input  wire logic       clk,
  // Register port and pin
  output logic            cs_wake_n,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       ack
);
  logic [7:0] q;
  logic       got;
  initial begin
    cs_wake_n = 1'b1;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    addr      = 8'h00;
    wdata     = 8'h00;
  end
  // One byte; released bus shows inverted value, not the last one
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cs_wake_n <= 1'b0;
    wr_en     <= w;
    rd_en     <= ~w;
    addr      <= a;
    wdata     <= d;
    @(posedge clk);
    wr_en     <= 1'b0;
    rd_en     <= 1'b0;
    addr      <= ~a;
    wdata     <= ~d;
    cs_wake_n <= 1'b1;
    // Answer taken at the edge where the acknowledge is sampled
    @(posedge clk);
    got = ack;
    q   = rdata;
  endtask : xfer
  task automatic pin(input logic v);
    @(posedge clk);
    cs_wake_n <= v;
  endtask : pin
endmodule : bhms_host
`default_nettype wire

/* sim/bhms_sequencer_bench.sv */
// Register-level bench of the mode sequencer
`timescale 1ns/10ps
`default_nettype none
module bhms_sequencer_bench;
  logic        clk, rst, supply_ok, strap;
  logic [7:0]  temp;
  logic [11:0] mag;
  wire logic   cs_n, wr, rd, ack, oe, bo, sb, ac, hb;
  wire logic [7:0] a, d, q, nxt;
  int          errors, num_checks;
  int          oe_len, pulse_len, pulses;
  // Boot-complete pulse width and count, seen from the pins
  always @(posedge clk) begin
    if (oe === 1'b1) begin
      oe_len <= oe_len + 1;
    end else begin
      oe_len <= 0;
    end
    if (oe !== 1'b1 && oe_len != 0) begin
      pulse_len <= oe_len;
      pulses    <= pulses + 1;
    end
  end
  bhms_sequencer #(.BOOT_SEQ_CYC(4), .BOOT_PULSE_CYC(4), .WAKE_FLT_CYC(3), .HIB_DELAY_CYC(250)) dut_u (
    .clk(clk), .rst(rst), .supply_ok(supply_ok), .boot_variant_strap(strap), .cs_wake_n(cs_n),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(a), .reg_wdata(d), .reg_rdata(q), .burst_next_addr(nxt),
    .reg_ack(ack), .temp_data(temp), .vec_mag(mag), .boot_out_o(bo), .boot_out_oe(oe),
    .mode_standby(sb), .mode_active(ac), .mode_hibernate(hb));
  bhms_host host_u (.clk(clk), .cs_wake_n(cs_n), .wr_en(wr), .rd_en(rd), .addr(a), .wdata(d),
    .rdata(q), .ack(ack));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
    host_u.xfer(1'b0, ad, 8'h00);
    check("rdata", host_u.q, e);
  endtask : rdc
  task automatic nx(input logic [7:0] ad, input logic [7:0] e);
    host_u.xfer(1'b0, ad, 8'h00);
    check("next_addr", nxt, e);
  endtask : nx
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Bounded wait; standby must follow each boot
  task automatic wait_sb;
    for (int i = 0; i < 60 && sb !== 1'b1; i++) @(posedge clk);
    #1;
    check("standby", {7'h00, sb}, 8'h01);
    check("pulse_len", 8'(pulse_len), 8'h04);
    check("boot_out_o", {7'h00, bo}, 8'h00);
  endtask : wait_sb
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #16000;
    errors++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    supply_ok = 1'b1;
    strap = 1'b0;
    temp = 8'h5A;
    mag = 12'hABC;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_sb();
    check("pulses", 8'(pulses), 8'h01);
    rdc(8'h00, 8'h01);
    rdc(8'h00, 8'h00);
    host_u.xfer(1'b1, 8'h00, 8'hFF);
    rdc(8'h00, 8'h00);
    rdc(8'h01, 8'h5A);
    rdc(8'h02, 8'hBC);
    rdc(8'h7F, 8'h00);
    nx(8'h00, 8'h04);
    host_u.xfer(1'b1, 8'h16, 8'h03);
    rdc(8'h02, 8'hAB);
    nx(8'h00, 8'h01);
    nx(8'h01, 8'h04);
    host_u.xfer(1'b1, 8'h19, 8'h02);
    nx(8'h01, 8'h02);
    host_u.xfer(1'b1, 8'h16, 8'h00);
    nx(8'h00, 8'h02);
    host_u.xfer(1'b1, 8'h15, 8'h01);
    cyc(1);
    check("active", {7'h00, ac}, 8'h01);
    rdc(8'h02, 8'hBC);
    host_u.xfer(1'b1, 8'h15, 8'h00);
    cyc(1);
    check("standby", {7'h00, sb}, 8'h01);
    host_u.xfer(1'b1, 8'h19, 8'h01);
    cyc(200);
    check("hibernate", {7'h00, hb}, 8'h00);
    rdc(8'h00, 8'h00);
    cyc(200);
    check("hibernate", {7'h00, hb}, 8'h00);
    cyc(60);
    check("hibernate", {7'h00, hb}, 8'h01);
    host_u.xfer(1'b0, 8'h00, 8'h00);
    check("ack", {7'h00, host_u.got}, 8'h00);
    cyc(5);
    check("hibernate", {7'h00, hb}, 8'h01);
    host_u.pin(1'b0);
    wait_sb();
    check("pulses", 8'(pulses), 8'h02);
    host_u.pin(1'b1);
    rdc(8'h00, 8'h01);
    cyc(260);
    check("hibernate", {7'h00, hb}, 8'h00);
    // Supply dip in standby reboots with fresh sensor data
    @(posedge clk);
    supply_ok <= 1'b0;
    temp      <= 8'hC3;
    mag       <= 12'h5E7;
    cyc(3);
    check("standby", {7'h00, sb}, 8'h00);
    host_u.xfer(1'b0, 8'h00, 8'h00);
    check("ack", {7'h00, host_u.got}, 8'h00);
    @(posedge clk);
    supply_ok <= 1'b1;
    wait_sb();
    check("pulses", 8'(pulses), 8'h03);
    rdc(8'h00, 8'h01);
    rdc(8'h01, 8'hC3);
    rdc(8'h02, 8'hE7);
    // Second reset with the other strap parks in hibernate
    @(posedge clk);
    rst   <= 1'b1;
    strap <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cyc(20);
    check("hibernate", {7'h00, hb}, 8'h01);
    check("standby", {7'h00, sb}, 8'h00);
    check("pulses", 8'(pulses), 8'h04);
    conclude();
  end
endmodule : bhms_sequencer_bench
`default_nettype wire

/* sim/bhms_sequencer_chk.sv */
// Port checker of the mode sequencer
`timescale 1ns/10ps
`default_nettype none
module bhms_sequencer_chk #(
  parameter int unsigned BOOT_PULSE_CYC = 4,
  parameter int unsigned HIB_DELAY_CYC  = 250
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Inputs
  input wire logic       supply_ok,
  input wire logic       boot_variant_strap,
  input wire logic       cs_wake_n,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Outputs
  input wire logic       reg_ack,
  input wire logic [7:0] burst_next_addr,
  input wire logic       boot_out_oe,
  input wire logic       mode_standby,
  input wire logic       mode_active,
  input wire logic       mode_hibernate
);
  int unsigned pcnt;
  int unsigned hcnt;
  wire logic   live = mode_standby | mode_active;
  wire logic   req  = reg_wr_en | reg_rd_en;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcnt <= 0;
      hcnt <= 0;
    end else begin
      pcnt <= boot_out_oe ? pcnt + 1 : 0;
      hcnt <= cs_wake_n ? hcnt + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  pulse_len_a: assert property ($fell(boot_out_oe) |-> pcnt == BOOT_PULSE_CYC)
    else $error("boot pulse width wrong");
  boot_standby_a: assert property ($fell(boot_out_oe) && !boot_variant_strap && supply_ok |-> mode_standby)
    else $error("no standby after boot");
  hib_wait_a: assert property ($rose(mode_hibernate) && $past(live)
    |-> hcnt inside {[HIB_DELAY_CYC-1:HIB_DELAY_CYC+3]})
    else $error("hibernate entry timing wrong");
  wake_boot_a: assert property ($fell(mode_hibernate) && supply_ok |-> !$past(cs_wake_n) ##[1:12] boot_out_oe)
    else $error("wake without pin or boot");
  active_go_a: assert property (reg_wr_en && mode_standby && reg_addr == 8'h15 && reg_wdata[0] |-> ##2 mode_active)
    else $error("active mode not entered");
  modes_excl_a: assert property ($onehot0({mode_standby, mode_active, mode_hibernate}))
    else $error("modes overlap");
  refuse_a: assert property (req && !live |=> !reg_ack)
    else $error("access acked while asleep");
  ack_live_a: assert property (req && live |=> reg_ack)
    else $error("access not acked");
  burst_step_a: assert property (reg_rd_en && live && reg_addr > 8'h01 |=> burst_next_addr == $past(reg_addr) + 8'h01)
    else $error("burst address wrong");
endmodule : bhms_sequencer_chk
bind bhms_sequencer bhms_sequencer_chk #(
  .BOOT_PULSE_CYC(BOOT_PULSE_CYC),
  .HIB_DELAY_CYC (HIB_DELAY_CYC)
) chk_u (
  .clk               (clk),
  .rst               (rst),
  .supply_ok         (supply_ok),
  .boot_variant_strap(boot_variant_strap),
  .cs_wake_n         (cs_wake_n),
  .reg_wr_en         (reg_wr_en),
  .reg_rd_en         (reg_rd_en),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_ack           (reg_ack),
  .burst_next_addr   (burst_next_addr),
  .boot_out_oe       (boot_out_oe),
  .mode_standby      (mode_standby),
  .mode_active       (mode_active),
  .mode_hibernate    (mode_hibernate)
);
`default_nettype wire

/* verilog/bhms_defines.svh */
// Addresses, field positions, reset values and timing figures of the mode sequencer
`ifndef BHMS_DEFINES_SVH
`define BHMS_DEFINES_SVH
`define BHMS_ADDR_EVENT       8'h00
`define BHMS_ADDR_TEMP        8'h01
`define BHMS_ADDR_MAG_LO      8'h02
`define BHMS_ADDR_MAG_HI      8'h03
`define BHMS_ADDR_PAST_MAG    8'h04
`define BHMS_ADDR_CTRL_A      8'h15
`define BHMS_ADDR_CTRL_B      8'h16
`define BHMS_ADDR_CTRL_E      8'h19
`define BHMS_CTRL_A_RUN_BIT   0
`define BHMS_CTRL_B_ORDER_BIT 0
`define BHMS_CTRL_B_TEMP_BIT  1
`define BHMS_CTRL_E_SLEEP_BIT 0
`define BHMS_CTRL_E_MAG_BIT   1
`define BHMS_EVENT_RESET      8'h01
`define BHMS_EVENT_BOOT_BIT   0
`define BHMS_CTRL_RESET       8'h00
`define BHMS_ZERO_BYTE        8'h00
`define BHMS_STRAP_HOST       1'b0
`define BHMS_CLK_MHZ          250
`define BHMS_HIB_DELAY_NS     1000
`define BHMS_HIB_DELAY_CYC    ((`BHMS_HIB_DELAY_NS * `BHMS_CLK_MHZ + 999) / 1000)
`define BHMS_WAKE_FLT_NS      1000
`define BHMS_WAKE_FLT_CYC     ((`BHMS_WAKE_FLT_NS * `BHMS_CLK_MHZ + 999) / 1000)
`define BHMS_BOOT_PULSE_US    1000
`define BHMS_BOOT_PULSE_CYC   ((`BHMS_BOOT_PULSE_US * `BHMS_CLK_MHZ))
`define BHMS_BOOT_SEQ_US      1000
`define BHMS_BOOT_SEQ_CYC     ((`BHMS_BOOT_SEQ_US * `BHMS_CLK_MHZ))
`endif

/* verilog/bhms_pkg.sv */
// Types of the boot and hibernate mode sequencer
package bhms_pkg;
  typedef enum logic [2:0] {
    BHMS_OFF,
    BHMS_BOOT,
    BHMS_PULSE,
    BHMS_STANDBY,
    BHMS_ACTIVE,
    BHMS_HIBERNATE
  } bhms_state_t;
endpackage : bhms_pkg

/* verilog/bhms_sequencer.sv */
// Boot, standby, hibernate and active mode sequencer with its first status registers
//
// Contract
// - Supply at minimum runs boot, then one boot-complete pulse of set width.
// - Host-strapped variant goes to standby after every boot.
// - Writing one to the deep-sleep bit requests hibernate.
// - Hibernate starts about 1us after chip select rises, never mid-transaction.
// - Wake pin toggle, deglitched, reruns boot and its pulse.
// - Writing one to the run bit in standby enters active mode.
// - Read-only event flag register at 00h, resets to 01h.
// - Temperature at 01h; burst skips it while temp include is zero.
// - Magnitude byte at 02h: bits 7:0 or 11:4 by byte order.
// - Burst skips magnitude registers while magnitude enable is zero.
`include "bhms_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module bhms_sequencer
  import bhms_pkg::*;
#(
  parameter int unsigned BOOT_SEQ_CYC   = `BHMS_BOOT_SEQ_CYC,
  parameter int unsigned BOOT_PULSE_CYC = `BHMS_BOOT_PULSE_CYC,
  parameter int unsigned WAKE_FLT_CYC   = `BHMS_WAKE_FLT_CYC,
  parameter int unsigned HIB_DELAY_CYC  = `BHMS_HIB_DELAY_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Supply and strap
  input  wire logic        supply_ok,
  input  wire logic        boot_variant_strap,
  // Chip select and wake pin
  input  wire logic        cs_wake_n,
  // Register access from the serial front end
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic      [7:0]  burst_next_addr,
  output logic             reg_ack,
  // Sensor data
  input  wire logic [7:0]  temp_data,
  input  wire logic [11:0] vec_mag,
  // Boot-complete open-drain pin
  output logic             boot_out_o,
  output logic             boot_out_oe,
  // Mode indication
  output logic             mode_standby,
  output logic             mode_active,
  output logic             mode_hibernate
);

  localparam logic [31:0] BOOT_LAST  = 32'(BOOT_SEQ_CYC - 1);
  localparam logic [31:0] PULSE_LAST = 32'(BOOT_PULSE_CYC - 1);
  localparam logic [31:0] WAKE_LAST  = 32'(WAKE_FLT_CYC - 1);
  localparam logic [31:0] HIB_LAST   = 32'(HIB_DELAY_CYC - 1);

  bhms_state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [7:0]  event_reg, event_next;
  logic [7:0]  ctrl_a_reg, ctrl_b_reg, ctrl_e_reg;
  logic        sleep_arm_reg, sleep_arm_next;
  logic        cs_ref_reg;
  logic        strap_reg;
  logic        strap_taken_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  next_addr_reg;
  logic        ack_reg;

  // Decode
  wire       acc_ok      = (state_reg == BHMS_STANDBY) || (state_reg == BHMS_ACTIVE);
  wire       wr_ok       = reg_wr_en && acc_ok;
  wire       rd_ok       = reg_rd_en && acc_ok;
  wire       wr_ctrl_a   = wr_ok && (reg_addr == `BHMS_ADDR_CTRL_A);
  wire       wr_ctrl_b   = wr_ok && (reg_addr == `BHMS_ADDR_CTRL_B);
  wire       wr_ctrl_e   = wr_ok && (reg_addr == `BHMS_ADDR_CTRL_E);
  wire       rd_event    = rd_ok && (reg_addr == `BHMS_ADDR_EVENT);
  wire       temp_inc    = ctrl_b_reg[`BHMS_CTRL_B_TEMP_BIT];
  wire       byte_order  = ctrl_b_reg[`BHMS_CTRL_B_ORDER_BIT];
  wire       mag_en      = ctrl_e_reg[`BHMS_CTRL_E_MAG_BIT];
  wire       run_bit     = ctrl_a_reg[`BHMS_CTRL_A_RUN_BIT];
  wire       sleep_req   = wr_ctrl_e && reg_wdata[`BHMS_CTRL_E_SLEEP_BIT];
  wire       pulse_done  = (state_reg == BHMS_PULSE) && (cnt_reg == PULSE_LAST);
  wire       host_var    = (strap_reg == `BHMS_STRAP_HOST);
  wire       cs_moved    = (cs_wake_n != cs_ref_reg);
  wire [7:0] mag_byte    = byte_order ? vec_mag[11:4] : vec_mag[7:0];
  wire [7:0] after_mag   = mag_en ? `BHMS_ADDR_MAG_LO : `BHMS_ADDR_PAST_MAG;
  wire [7:0] after_event = temp_inc ? `BHMS_ADDR_TEMP : after_mag;
  wire [7:0] addr_plus   = reg_addr + 8'h01;

  // Read mux; unmapped addresses read as zero
  logic [7:0] rd_mux;
  logic [7:0] nxt_mux;
  always_comb begin
    case (reg_addr)
      `BHMS_ADDR_EVENT:  rd_mux = event_reg;
      `BHMS_ADDR_TEMP:   rd_mux = temp_data;
      `BHMS_ADDR_MAG_LO: rd_mux = mag_byte;
      `BHMS_ADDR_CTRL_A: rd_mux = ctrl_a_reg;
      `BHMS_ADDR_CTRL_B: rd_mux = ctrl_b_reg;
      `BHMS_ADDR_CTRL_E: rd_mux = ctrl_e_reg;
      default:           rd_mux = `BHMS_ZERO_BYTE;
    endcase
    case (reg_addr)
      `BHMS_ADDR_EVENT: nxt_mux = after_event;
      `BHMS_ADDR_TEMP:  nxt_mux = after_mag;
      default:          nxt_mux = addr_plus;
    endcase
  end

  // Boot-complete event sets the flag and wins over a clearing read
  always_comb begin
    event_next = event_reg;
    if (rd_event) begin
      event_next[`BHMS_EVENT_BOOT_BIT] = 1'b0;
    end
    if (pulse_done) begin
      event_next[`BHMS_EVENT_BOOT_BIT] = 1'b1;
    end
  end

  // Mode sequencing
  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg + 32'h1;
    sleep_arm_next = sleep_arm_reg || sleep_req;
    case (state_reg)
      BHMS_OFF: begin
        cnt_next = '0;
        if (supply_ok && strap_taken_reg) begin
          state_next = BHMS_BOOT;
        end
      end
      BHMS_BOOT: begin
        sleep_arm_next = 1'b0;
        if (cnt_reg == BOOT_LAST) begin
          state_next = BHMS_PULSE;
          cnt_next   = '0;
        end
      end
      BHMS_PULSE: begin
        if (pulse_done) begin
          // Other strap variant is not supported here; it parks in hibernate
          state_next = host_var ? BHMS_STANDBY : BHMS_HIBERNATE;
          cnt_next   = '0;
        end
      end
      BHMS_STANDBY, BHMS_ACTIVE: begin
        // Delay only counts once chip select is released after the request
        if (!sleep_arm_reg || !cs_wake_n) begin
          cnt_next = '0;
        end else if (cnt_reg == HIB_LAST) begin
          state_next = BHMS_HIBERNATE;
          cnt_next   = '0;
        end
        if (state_next != BHMS_HIBERNATE) begin
          state_next = run_bit ? BHMS_ACTIVE : BHMS_STANDBY;
        end
      end
      BHMS_HIBERNATE: begin
        sleep_arm_next = 1'b0;
        // A glitch back to the old level restarts the filter
        if (!cs_moved) begin
          cnt_next = '0;
        end else if (cnt_reg == WAKE_LAST) begin
          state_next = BHMS_BOOT;
          cnt_next   = '0;
        end
      end
      default: begin
        state_next = BHMS_OFF;
        cnt_next   = '0;
      end
    endcase
    if (!supply_ok) begin
      state_next = BHMS_OFF;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg     <= BHMS_OFF;
      cnt_reg       <= '0;
      sleep_arm_reg <= 1'b0;
      event_reg     <= `BHMS_EVENT_RESET;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      sleep_arm_reg <= sleep_arm_next;
      event_reg     <= event_next;
    end
  end

  // Strap caught on the first edge after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_reg       <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_reg       <= boot_variant_strap;
      strap_taken_reg <= 1'b1;
    end
  end

  // Wake reference level follows the pin outside hibernate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_ref_reg <= 1'b1;
    end else if (state_reg != BHMS_HIBERNATE) begin
      cs_ref_reg <= cs_wake_n;
    end
  end

  // Control registers return to defaults on every boot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_reg <= `BHMS_CTRL_RESET;
      ctrl_b_reg <= `BHMS_CTRL_RESET;
      ctrl_e_reg <= `BHMS_CTRL_RESET;
    end else if (state_reg == BHMS_BOOT) begin
      ctrl_a_reg <= `BHMS_CTRL_RESET;
      ctrl_b_reg <= `BHMS_CTRL_RESET;
      ctrl_e_reg <= `BHMS_CTRL_RESET;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_reg <= reg_wdata;
      end
      if (wr_ctrl_b) begin
        ctrl_b_reg <= reg_wdata;
      end
      if (wr_ctrl_e) begin
        ctrl_e_reg <= reg_wdata;
      end
    end
  end

  // Read data and burst address registered one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg     <= `BHMS_ZERO_BYTE;
      next_addr_reg <= `BHMS_ZERO_BYTE;
      ack_reg       <= 1'b0;
    end else begin
      ack_reg <= wr_ok || rd_ok;
      if (rd_ok) begin
        rdata_reg     <= rd_mux;
        next_addr_reg <= nxt_mux;
      end
    end
  end

  assign reg_rdata       = rdata_reg;
  assign burst_next_addr = next_addr_reg;
  assign reg_ack         = ack_reg;
  assign boot_out_o      = 1'b0;
  assign boot_out_oe     = (state_reg == BHMS_PULSE);
  assign mode_standby    = (state_reg == BHMS_STANDBY);
  assign mode_active     = (state_reg == BHMS_ACTIVE);
  assign mode_hibernate  = (state_reg == BHMS_HIBERNATE);

endmodule : bhms_sequencer
`default_nettype wire
